// >>> logic/wdog_bus_regs_pkg.sv
// Package for the watchdog and transceiver mode control register bank.
// Assumes a register-port access from the serial interface decoder.
`default_nettype none
package wdog_bus_regs_pkg;
  localparam logic [6:0] WDOG_CTRL_ADDR = 7'h03;
  localparam logic [6:0] XCVR_CTRL_ADDR = 7'h04;
  localparam logic [6:0] HARDWARE_CONTROL_REG_ADDR = 7'h02;
  localparam logic [15:0] WDOG_CTRL_RESET = 16'h0014;
  localparam logic [15:0] XCVR_CTRL_RESET = 16'h0020;
  localparam logic [15:0] WDOG_CTRL_RESTART_MASK = 16'h0010;
  localparam int CHECKSUM_BIT = 15;
  localparam int STOP_DIS_FIRST_BIT = 6;
  localparam int TYPE_SEL_BIT = 5;
  localparam int BUS_WAKE_BIT = 4;
  localparam int FAIL_REQ_BIT = 5;
  localparam int STOP_DIS_SECOND_BIT = 2;
  localparam logic [2:0] XCVR_WAKE = 3'h1;
  localparam logic [2:0] XCVR_RECV = 3'h2;
  localparam logic [2:0] XCVR_NORMAL = 3'h3;
  localparam logic [2:0] XCVR_FAILSAFE = 3'h1;
  // Period select values: index 0..7 maps to 10ms..10s
  localparam int PERIOD_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_RESTART = 2'b11
  } op_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic stop_disable;
    logic type_window;
    logic start_on_bus_wake;
    logic [2:0] period_sel;
    logic checksum;
  } wdog_cfg_type;
endpackage : wdog_bus_regs_pkg
`default_nettype wire

// >>> logic/wdog_bus_regs.sv
// Watchdog control, transceiver mode and fail-output request registers.
// Assumes decoded register accesses from the serial interface, one per cycle.
//
// Contract
// R1: Clearing the software fail request keeps fail outputs on while a failure latch holds.
// R2: Failure-activated fail outputs release only when software clears the failure latch.
// R3: Restart clears a set software fail request; outputs drop unless a failure remains.
// R4: Stop to normal transition clears the second stop watchdog disable bit.
// R5: Bit 15 of watchdog control is a stored checksum bit used in checksum.
// R6: Bit 6 is the first stop disable bit; 1 disables in stop; device may update.
// R7: Bit 5 selects watchdog type: 0 time-out, 1 window.
// R8: Bit 4 set lets a bus wake in stop start the watchdog with long window.
// R9: Three-bit period field selects 10 ms up to 10 s.
// R10: Reserved bits of both registers always read as zero.
// R11: Mode codes 000 to 011 select off, wake, receive-only, normal without selective wake.
// R12: Codes 100 to 111 add selective wake; device may update the field. The code sets selective_wake only for 101 to 111.
// R13: Software fail request drives the fail pin only when pin is configured fail-safe.
// R14: Sleep entry without system error turns normal or receive-only into wake-capable.
// R15: Watchdog is off in stop mode only if both stop disable bits are set.
`timescale 1ns/100ps
`default_nettype none
module wdog_bus_regs
  import wdog_bus_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire reg_req_type req,
  output logic [15:0] rdata,
  input wire op_mode_type op_mode,
  input wire logic failure_latched,
  input wire logic pin_is_fail_safe,
  input wire logic system_error_flag,
  input wire logic bus_wake_event,
  input wire logic failsafe_entry,
  output logic fail_output_pin,
  output var wdog_cfg_type wdog_cfg,
  output logic wdog_run_in_stop,
  output logic wdog_long_window_start,
  output logic [2:0] xcvr_mode,
  output logic selective_wake
);
  logic [15:0] wdog_ctrl_ff, nxt_wdog_ctrl;
  logic [2:0] xcvr_ff, nxt_xcvr;
  logic fail_req_ff, nxt_fail_req;
  logic stop_dis2_ff, nxt_stop_dis2;
  logic start_ff, nxt_start;
  logic [15:0] rdata_ff, nxt_rdata;
  op_mode_type mode_ff;
  logic wr_wd, wr_xc, wr_hw;

  assign wr_wd = req.wr && req.addr == WDOG_CTRL_ADDR;
  assign wr_xc = req.wr && req.addr == XCVR_CTRL_ADDR;
  assign wr_hw = req.wr && req.addr == HARDWARE_CONTROL_REG_ADDR;

  always_comb begin
    nxt_wdog_ctrl = wdog_ctrl_ff;
    nxt_xcvr = xcvr_ff;
    nxt_fail_req = fail_req_ff;
    nxt_stop_dis2 = stop_dis2_ff;
    nxt_start = 1'b0;
    nxt_rdata = rdata_ff;
    if (wr_wd) begin
      // Only implemented bits are stored, so reserved bits stay zero
      nxt_wdog_ctrl = req.wdata & 16'h8077; // R5 R6 R7 R8 R9 R10
    end
    if (wr_xc) begin
      nxt_xcvr = req.wdata[2:0]; // R11 R12
    end
    if (wr_hw) begin
      nxt_fail_req = req.wdata[FAIL_REQ_BIT]; // R13
      nxt_stop_dis2 = req.wdata[STOP_DIS_SECOND_BIT];
    end
    if (op_mode == MODE_SLEEP && mode_ff != MODE_SLEEP && !system_error_flag &&
        (nxt_xcvr[1:0] == XCVR_NORMAL[1:0] || nxt_xcvr[1:0] == XCVR_RECV[1:0])) begin
      nxt_xcvr = {nxt_xcvr[2], XCVR_WAKE[1:0]}; // R14
    end
    if (failsafe_entry) begin
      nxt_xcvr = XCVR_FAILSAFE;
    end
    if (mode_ff == MODE_STOP && op_mode == MODE_NORMAL) begin
      nxt_stop_dis2 = 1'b0; // R4
    end
    if (op_mode == MODE_RESTART && mode_ff != MODE_RESTART) begin
      nxt_fail_req = 1'b0; // R3
      nxt_stop_dis2 = 1'b0;
      nxt_wdog_ctrl = WDOG_CTRL_RESET & ~WDOG_CTRL_RESTART_MASK |
                      (wdog_ctrl_ff & WDOG_CTRL_RESTART_MASK);
    end
    if (soft_reset) begin
      nxt_wdog_ctrl = WDOG_CTRL_RESET;
      nxt_xcvr = XCVR_CTRL_RESET[2:0];
      nxt_fail_req = 1'b0;
      nxt_stop_dis2 = 1'b0;
    end
    if (op_mode == MODE_STOP && bus_wake_event && wdog_ctrl_ff[BUS_WAKE_BIT]) begin
      nxt_start = 1'b1; // R8
    end
    if (req.rd) begin
      unique case (req.addr)
        WDOG_CTRL_ADDR: nxt_rdata = wdog_ctrl_ff & 16'h8077; // R10
        XCVR_CTRL_ADDR: nxt_rdata = {13'h0000, xcvr_ff}; // R10
        HARDWARE_CONTROL_REG_ADDR: nxt_rdata = {10'h000, fail_req_ff, 2'h0, stop_dis2_ff, 2'h0};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_ctrl_ff <= WDOG_CTRL_RESET;
      xcvr_ff <= XCVR_CTRL_RESET[2:0];
      fail_req_ff <= 1'b0;
      stop_dis2_ff <= 1'b0;
      start_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      mode_ff <= MODE_NORMAL;
    end else begin
      wdog_ctrl_ff <= nxt_wdog_ctrl;
      xcvr_ff <= nxt_xcvr;
      fail_req_ff <= nxt_fail_req;
      stop_dis2_ff <= nxt_stop_dis2;
      start_ff <= nxt_start;
      rdata_ff <= nxt_rdata;
      mode_ff <= op_mode;
    end
  end

  // Failure path is independent of the software request, so clearing it never drops it
  assign fail_output_pin = failure_latched || (fail_req_ff && pin_is_fail_safe); // R1 R2 R13
  assign rdata = rdata_ff;
  assign wdog_cfg = '{
    stop_disable: wdog_ctrl_ff[STOP_DIS_FIRST_BIT], // R6
    type_window: wdog_ctrl_ff[TYPE_SEL_BIT], // R7
    start_on_bus_wake: wdog_ctrl_ff[BUS_WAKE_BIT], // R8
    period_sel: wdog_ctrl_ff[2:0], // R9
    checksum: wdog_ctrl_ff[CHECKSUM_BIT] // R5
  };
  assign wdog_run_in_stop = !(wdog_ctrl_ff[STOP_DIS_FIRST_BIT] && stop_dis2_ff); // R15
  assign wdog_long_window_start = start_ff;
  assign xcvr_mode = xcvr_ff;
  assign selective_wake = xcvr_ff[2] && xcvr_ff[1:0] != 2'b00; // R12

  property p_fail_hold;
    @(posedge clk) disable iff (!rst_n) failure_latched |-> fail_output_pin;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail pin dropped"); // R1

  property p_fail_release;
    @(posedge clk) disable iff (!rst_n)
      $fell(failure_latched) && !fail_req_ff |-> !fail_output_pin;
  endproperty
  a_fail_release: assert property (p_fail_release) else $error("fail pin held"); // R2

  property p_restart_clear;
    @(posedge clk) disable iff (!rst_n)
      op_mode == MODE_RESTART && mode_ff != MODE_RESTART |=> !fail_req_ff;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("request kept"); // R3

  property p_stop_exit;
    @(posedge clk) disable iff (!rst_n)
      mode_ff == MODE_STOP && op_mode == MODE_NORMAL |=> !stop_dis2_ff;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("disable bit kept"); // R4

  property p_wd_write;
    @(posedge clk) disable iff (!rst_n)
      wr_wd && !soft_reset && op_mode != MODE_RESTART |=> wdog_cfg.checksum == $past(req.wdata[15])
        && wdog_cfg.period_sel == $past(req.wdata[2:0]);
  endproperty
  a_wd_write: assert property (p_wd_write) else $error("watchdog write lost"); // R5

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      req.rd && (req.addr == WDOG_CTRL_ADDR || req.addr == XCVR_CTRL_ADDR) |=>
        (rdata & ($past(req.addr) == WDOG_CTRL_ADDR ? 16'h7F88 : 16'hFFF8)) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R10

  property p_bus_wake;
    @(posedge clk) disable iff (!rst_n)
      op_mode == MODE_STOP && bus_wake_event && !wdog_cfg.start_on_bus_wake |=>
        !wdog_long_window_start;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("start without enable"); // R8

  property p_stop_both;
    @(posedge clk) disable iff (!rst_n)
      wdog_run_in_stop == !(wdog_cfg.stop_disable && stop_dis2_ff);
  endproperty
  a_stop_both: assert property (p_stop_both) else $error("stop run wrong"); // R15

  property p_sw_fail;
    @(posedge clk) disable iff (!rst_n)
      !failure_latched && !pin_is_fail_safe |-> !fail_output_pin;
  endproperty
  a_sw_fail: assert property (p_sw_fail) else $error("fail pin without fail-safe"); // R13

  property p_sleep_fallback;
    @(posedge clk) disable iff (!rst_n)
      op_mode == MODE_SLEEP && mode_ff != MODE_SLEEP && !system_error_flag && xcvr_ff[1] &&
        !wr_xc && !soft_reset && !failsafe_entry |=>
        xcvr_mode[1:0] == XCVR_WAKE[1:0] && xcvr_mode[2] == $past(xcvr_ff[2]);
  endproperty
  a_sleep_fallback: assert property (p_sleep_fallback) else $error("no wake fallback"); // R14

  property p_xcvr_write;
    @(posedge clk) disable iff (!rst_n)
      wr_xc && !soft_reset && !failsafe_entry && !(op_mode == MODE_SLEEP && mode_ff != MODE_SLEEP)
        |=> xcvr_mode == $past(req.wdata[2:0]);
  endproperty
  a_xcvr_write: assert property (p_xcvr_write) else $error("mode write lost"); // R11

  property p_restart_load;
    @(posedge clk) disable iff (!rst_n)
      op_mode == MODE_RESTART && mode_ff != MODE_RESTART && !soft_reset |=>
        wdog_cfg.start_on_bus_wake == $past(wdog_cfg.start_on_bus_wake) &&
        wdog_cfg.period_sel == WDOG_CTRL_RESET[2:0] && !stop_dis2_ff;
  endproperty
  a_restart_load: assert property (p_restart_load) else $error("restart reload wrong"); // R8

  property p_long_start;
    @(posedge clk) disable iff (!rst_n)
      op_mode == MODE_STOP && bus_wake_event && wdog_cfg.start_on_bus_wake |=>
        wdog_long_window_start;
  endproperty
  a_long_start: assert property (p_long_start) else $error("no start after bus wake"); // R8

  property p_wd_flags;
    @(posedge clk) disable iff (!rst_n)
      wr_wd && !soft_reset && op_mode != MODE_RESTART |=>
        wdog_cfg.stop_disable == $past(req.wdata[6]) &&
        wdog_cfg.type_window == $past(req.wdata[5]) &&
        wdog_cfg.start_on_bus_wake == $past(req.wdata[4]);
  endproperty
  a_wd_flags: assert property (p_wd_flags) else $error("watchdog flag write lost"); // R6
endmodule : wdog_bus_regs
`default_nettype wire

// >>> sim/host_model.sv
// Host side model: one register access per call of its task.
// Assumes the bench calls it from one process, off the clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_model
  import wdog_bus_regs_pkg::*;
(
  input wire logic clk,
  output var reg_req_type req
);
  initial req = '0;
  // Request held for exactly one edge, then dropped so a pulse is never stretched
  task automatic access(input logic w, input logic [6:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
  endtask : access
endmodule : host_model
`default_nettype wire

// >>> sim/watchdog_and_bus_mode_control_regs_bench.sv
// Self-checking bench for the watchdog and transceiver mode registers.
// Assumes host_model issues register requests; other inputs driven here.
`timescale 1ns/100ps
`default_nettype none
module watchdog_and_bus_mode_control_regs_bench;
  import wdog_bus_regs_pkg::*;
  logic clk = 0, rst_n = 0, soft_reset = 0, failure_latched = 0, pin_is_fail_safe = 0;
  logic system_error_flag = 0, bus_wake_event = 0, failsafe_entry = 0;
  op_mode_type op_mode = MODE_NORMAL;
  reg_req_type req;
  logic [15:0] rdata, d;
  wdog_cfg_type wdog_cfg;
  logic fail_output_pin, wdog_run_in_stop, wdog_long_window_start, selective_wake;
  logic [2:0] xcvr_mode;
  int err_count = 0, checks = 0, cycles = 0;
  integer seed = 32'h6a15;
  always #10 clk = ~clk;
  host_model i_host_model (.clk, .req);
  wdog_bus_regs i_wdog_bus_regs (.clk, .rst_n, .soft_reset, .req, .rdata, .op_mode,
    .failure_latched, .pin_is_fail_safe, .system_error_flag, .bus_wake_event,
    .failsafe_entry, .fail_output_pin, .wdog_cfg, .wdog_run_in_stop,
    .wdog_long_window_start, .xcvr_mode, .selective_wake);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Ceiling well above the roughly 200 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    i_host_model.access(1'b1, a, v);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    i_host_model.access(1'b0, a, 16'h0000);
    #1 check(rdata, exp);
  endtask : rd
  task automatic go(input op_mode_type m);
    @(posedge clk) op_mode <= m;
    @(posedge clk) #1;
  endtask : go
  function automatic logic [15:0] cfg_exp(input logic [15:0] v);
    return {9'h000, v[6], v[5], v[4], v[2:0], v[15]};
  endfunction : cfg_exp
  task automatic wake(input logic b);
    wr(7'h03, {11'h000, b, 4'h0});
    @(posedge clk) bus_wake_event <= 1'b1;
    @(posedge clk) bus_wake_event <= 1'b0;
    #1 check(16'(wdog_long_window_start), 16'(b));
  endtask : wake
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(7'h03, 16'h0014);
    check(16'(wdog_cfg), cfg_exp(16'h0014));
    rd(7'h04, 16'h0000);
    rd(7'h7F, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      d[2:0] = i[2:0];
      wr(7'h03, d);
      check(16'(wdog_cfg), cfg_exp(d));
      rd(7'h03, d & 16'h8077);
      wr(7'h04, d);
      check(16'({xcvr_mode, selective_wake}), 16'({d[2:0], d[2:0] > 3'h4}));
      rd(7'h04, {13'h0000, d[2:0]});
    end
    @(posedge clk) pin_is_fail_safe <= 1'b1;
    wr(7'h02, 16'h0020);
    check(16'(fail_output_pin), 16'h0001);
    @(posedge clk) pin_is_fail_safe <= 1'b0;
    #1 check(16'(fail_output_pin), 16'h0000);
    @(posedge clk) failure_latched <= 1'b1;
    wr(7'h02, 16'h0000);
    check(16'(fail_output_pin), 16'h0001);
    @(posedge clk) failure_latched <= 1'b0;
    #1 check(16'(fail_output_pin), 16'h0000);
    @(posedge clk) pin_is_fail_safe <= 1'b1;
    wr(7'h02, 16'h0020);
    wr(7'h03, 16'h0000);
    go(MODE_RESTART);
    go(MODE_NORMAL);
    rd(7'h02, 16'h0000);
    check(16'(fail_output_pin), 16'h0000);
    rd(7'h03, 16'h0004);
    wr(7'h03, 16'h0040);
    wr(7'h02, 16'h0004);
    check(16'(wdog_run_in_stop), 16'h0000);
    go(MODE_STOP);
    go(MODE_NORMAL);
    rd(7'h02, 16'h0000);
    check(16'(wdog_run_in_stop), 16'h0001);
    go(MODE_STOP);
    wake(1'b1);
    wake(1'b0);
    go(MODE_NORMAL);
    // Normal and receive-only fall back to wake-capable unless an error is flagged
    for (int j = 0; j < 4; j++) begin
      @(posedge clk) system_error_flag <= (j == 2);
      wr(7'h04, (j == 1) ? 16'h0002 : ((j == 3) ? 16'h0007 : 16'h0003));
      go(MODE_SLEEP);
      rd(7'h04, (j == 2) ? 16'h0003 : ((j == 3) ? 16'h0005 : 16'h0001));
      go(MODE_NORMAL);
    end
    @(posedge clk) failsafe_entry <= 1'b1;
    @(posedge clk) failsafe_entry <= 1'b0;
    rd(7'h04, 16'h0001);
    wr(7'h03, 16'h8077);
    wr(7'h04, 16'h0007);
    wr(7'h02, 16'h0024);
    @(posedge clk) soft_reset <= 1'b1;
    @(posedge clk) soft_reset <= 1'b0;
    rd(7'h03, 16'h0014);
    rd(7'h04, 16'h0000);
    rd(7'h02, 16'h0000);
    check(16'(fail_output_pin), 16'h0000);
    wr(7'h02, 16'h0020);
    check(16'(fail_output_pin), 16'h0001);
    wr(7'h03, 16'h0063);
    // Mid-run power-on reset must drop the software request and reload the watchdog
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 check(16'(fail_output_pin), 16'h0000);
    check(16'(wdog_cfg), cfg_exp(16'h0014));
    rd(7'h03, 16'h0014);
    close_out();
  end
endmodule : watchdog_and_bus_mode_control_regs_bench
`default_nettype wire
